// ===== core/gpio_ports.sv
// programmable i/o ports: direction, latch, pin sense, group pull-ups
// assumes pins and peripheral signals synchronous to clk; pads resolved outside
//
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "gpio_defs.svh"
module gpio_ports #(
    parameter int NUM_PORTS = 11
) (
    input  wire logic                   clk,
    input  wire logic                   rstn,
    input  wire gpio_pkg::gpio_req_t    bus_req,
    output logic [`GPIO_DW-1:0]         rdata_q,
    input  wire logic [NUM_PORTS*8-1:0] pad_in,
    output logic [NUM_PORTS*8-1:0]      pad_out_q,
    output logic [NUM_PORTS*8-1:0]      pad_oe_q,
    output logic [NUM_PORTS*8-1:0]      pull_en_q,
    input  wire logic [NUM_PORTS*8-1:0] periph_oe,
    input  wire logic [NUM_PORTS*8-1:0] periph_out,
    input  wire logic [NUM_PORTS*8-1:0] periph_dac
);
    localparam int NB = NUM_PORTS * 8;
    localparam int NG = NB / `GPIO_GROUP_W;

    // map holds at most 12 ports so direction words stay below the pull-up words;
    // the input-only bit lives in port 8
    if (NUM_PORTS < 9 || NUM_PORTS > 12)
    begin : g_bad_ports
        $error("gpio_ports: NUM_PORTS must be 9..12");
    end

    // pull-up words must cover every group of four pins
    if (NG > `GPIO_PULL_REGS * 8)
    begin : g_bad_groups
        $error("gpio_ports: too few pull-up bits for the groups");
    end

    function automatic gpio_pkg::gpio_sel_t dec(input logic [`GPIO_AW-1:0] a);
        if (a < `GPIO_DATA_BASE + 5'(NUM_PORTS))
            dec = gpio_pkg::GPIO_SEL_DATA;
        else if (a >= `GPIO_DIR_BASE && a < `GPIO_DIR_BASE + 5'(NUM_PORTS))
            dec = gpio_pkg::GPIO_SEL_DIR;
        else if (a >= `GPIO_PULL_BASE)
            dec = gpio_pkg::GPIO_SEL_PULL;
        else
            dec = gpio_pkg::GPIO_SEL_NONE;
    endfunction : dec

    logic [NB-1:0]                   dir_q;
    logic [NB-1:0]                   dir_d;
    logic [NB-1:0]                   latch_q;
    logic [NB-1:0]                   latch_d;
    logic [`GPIO_PULL_REGS*8-1:0]    pull_q;
    logic [`GPIO_PULL_REGS*8-1:0]    pull_d;
    logic [`GPIO_DW-1:0]             rdata_d;
    logic [NB-1:0]                   oe_d;
    logic [NB-1:0]                   out_d;
    logic [NB-1:0]                   pen_d;
    gpio_pkg::gpio_sel_t             sel;
    logic [3:0]                      idx;

    // register port: writes and registered read data
    always_comb
    begin
        dir_d   = dir_q;
        latch_d = latch_q;
        pull_d  = pull_q;
        rdata_d = '0;
        sel     = dec(bus_req.addr);
        idx     = bus_req.addr[3:0];
        if (bus_req.we)
        begin
            unique case (sel)
                gpio_pkg::GPIO_SEL_DATA: latch_d[idx*8 +: 8] = bus_req.wdata;
                gpio_pkg::GPIO_SEL_DIR:  dir_d[idx*8 +: 8] = bus_req.wdata;
                gpio_pkg::GPIO_SEL_PULL: pull_d[idx[1:0]*8 +: 8] = bus_req.wdata;
                gpio_pkg::GPIO_SEL_NONE: ;
            endcase
        end
        // no direction storage on input-only bit
        dir_d[`GPIO_IN_ONLY_BIT] = 1'b0;
        if (bus_req.re)
        begin
            unique case (sel)
                // reads sense the pin, not the latch
                gpio_pkg::GPIO_SEL_DATA: rdata_d = pad_in[idx*8 +: 8];
                gpio_pkg::GPIO_SEL_DIR:  rdata_d = dir_q[idx*8 +: 8];
                gpio_pkg::GPIO_SEL_PULL: rdata_d = pull_q[idx[1:0]*8 +: 8];
                gpio_pkg::GPIO_SEL_NONE: rdata_d = '0;
            endcase
        end
    end

    // pin drive: peripheral sharing, direction, pull-ups
    always_comb
    begin
        oe_d  = '0;
        out_d = '0;
        pen_d = '0;
        for (int i = 0; i < NB; i++)
        begin
            if (periph_oe[i] && !periph_dac[i])
            begin
                oe_d[i]  = 1'b1;
                out_d[i] = periph_out[i];
            end
            else
            begin
                // converter pin relies on direction kept at input
                oe_d[i]  = dir_q[i];
                out_d[i] = latch_q[i];
            end
            if (i == `GPIO_IN_ONLY_BIT)
                oe_d[i] = 1'b0;
            pen_d[i] = pull_q[i / `GPIO_GROUP_W] && !oe_d[i] && !dir_q[i];
        end
    end

    // all bits but the input-only direction bit kept, bonded or not
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dir_q   <= {NUM_PORTS{`GPIO_RST_DIR}};
            latch_q <= {NUM_PORTS{`GPIO_RST_LATCH}};
            pull_q  <= {`GPIO_PULL_REGS{`GPIO_RST_PULL}};
            rdata_q <= '0;
        end
        else
        begin
            dir_q   <= dir_d;
            latch_q <= latch_d;
            pull_q  <= pull_d;
            rdata_q <= rdata_d;
        end
    end

    // pins registered so no pad sees a decode glitch
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pad_oe_q  <= '0;
            pad_out_q <= '0;
            pull_en_q <= '0;
        end
        else
        begin
            pad_oe_q  <= oe_d;
            pad_out_q <= out_d;
            pull_en_q <= pen_d;
        end
    end

    logic first_q;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            first_q <= 1'b1;
        else
            first_q <= 1'b0;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_DIR_OUT: assert property (
        (!periph_oe[0] && dir_q[0]) |=> pad_oe_q[0] && pad_out_q[0] == $past(latch_q[0]))
        else $error("output direction did not drive pin 0");

    AST_DIR_IN: assert property (
        (!periph_oe[0] && !dir_q[0]) |=> !pad_oe_q[0])
        else $error("input direction still drives pin 0");

    AST_DIR_WRITE: assert property (
        (bus_req.we && bus_req.addr == `GPIO_DIR_BASE) |=> dir_q[7:0] == $past(bus_req.wdata))
        else $error("direction write did not land");

    AST_DIR_HOLD: assert property (
        !bus_req.we |=> $stable(dir_q))
        else $error("direction changed without a write");

    AST_READ_PIN: assert property (
        (bus_req.re && bus_req.addr == `GPIO_DATA_BASE) |=> rdata_q == $past(pad_in[7:0]))
        else $error("port read did not return pin state");

    AST_RD_IDLE: assert property (
        !bus_req.re |=> rdata_q == '0)
        else $error("read data stood without a read");

    AST_LATCH_IN: assert property (
        (bus_req.we && bus_req.addr == `GPIO_DATA_BASE && dir_q[7:0] == 8'h00)
        |=> latch_q[7:0] == $past(bus_req.wdata))
        else $error("latch not written while input");

    AST_LATCH_HOLD: assert property (
        !bus_req.we |=> $stable(latch_q))
        else $error("latch changed without a write");

    AST_PULL_WRITE: assert property (
        (bus_req.we && bus_req.addr == `GPIO_PULL_BASE) |=> pull_q[7:0] == $past(bus_req.wdata))
        else $error("pull-up write did not land");

    AST_PULL_GROUP: assert property (
        (pull_q[0] && dir_q[3:0] == 4'h0 && periph_oe[3:0] == 4'h0)
        |=> pull_en_q[3:0] == 4'hF)
        else $error("group pull-up not applied to all four pins");

    AST_PULL_HOLD: assert property (
        !bus_req.we |=> $stable(pull_q))
        else $error("pull-up setting changed without a write");

    AST_PULL_OUT: assert property (
        (pull_en_q & pad_oe_q) == '0)
        else $error("pull-up on a driven pin");

    AST_PULL_DIR: assert property (
        (pull_en_q & $past(dir_q)) == '0)
        else $error("pull-up on an output-direction pin");

    AST_PERIPH: assert property (
        (periph_oe[0] && !periph_dac[0])
        |=> pad_oe_q[0] && pad_out_q[0] == $past(periph_out[0]))
        else $error("peripheral output did not override direction");

    AST_PERIPH_PIN16: assert property (
        (periph_oe[16] && !periph_dac[16])
        |=> pad_oe_q[16] && pad_out_q[16] == $past(periph_out[16]))
        else $error("peripheral output did not reach pin 16");

    AST_DAC_HELD: assert property (
        (periph_oe[16] && periph_dac[16] && !dir_q[16])
        |=> !pad_oe_q[16])
        else $error("converter pin driven digitally");

    AST_IN_ONLY: assert property (
        !pad_oe_q[`GPIO_IN_ONLY_BIT] && !dir_q[`GPIO_IN_ONLY_BIT])
        else $error("input-only bit drives or holds direction");

    AST_IN_ONLY_READ: assert property (
        (bus_req.re && bus_req.addr == `GPIO_DIR_BASE + 5'h08)
        |=> !rdata_q[5])
        else $error("input-only bit shows a direction");

    AST_RESET_IN: assert property (
        first_q |-> dir_q == '0 && pad_oe_q == '0)
        else $error("direction not input after reset");

    AST_FIRST_QUIET: assert property (
        first_q |-> rdata_q == '0 && pull_en_q == '0)
        else $error("outputs not quiet after reset");

    AST_UNBONDED: assert property (
        (bus_req.we && bus_req.addr == `GPIO_DIR_BASE + 5'h01)
        |=> dir_q[15:8] == $past(bus_req.wdata))
        else $error("internal port one direction not kept");

    AST_UNBONDED_OUT: assert property (
        !periph_oe[8] |=> pad_out_q[8] == $past(latch_q[8]))
        else $error("internal port one latch not on its pad");

    // main scenarios
    COV_OUT_WRITE: cover property (
        bus_req.we && bus_req.addr == `GPIO_DIR_BASE ##1 pad_oe_q[0]);
    COV_PERIPH: cover property (periph_oe[0] && !dir_q[0] ##1 pad_oe_q[0]);
    COV_PULL: cover property (pull_en_q[3:0] == 4'hF);
    COV_DAC: cover property (periph_oe[16] && periph_dac[16] ##1 !pad_oe_q[16]);
    COV_IN_ONLY: cover property (
        bus_req.re && bus_req.addr == `GPIO_DIR_BASE + 5'h08);
endmodule : gpio_ports

// ===== core/gpio_defs.svh
// register map and field constants of the programmable port block
// assumes an 8-bit register port with 5-bit word addresses
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH
`define GPIO_AW          5
`define GPIO_DW          8
`define GPIO_DATA_BASE   5'h00
`define GPIO_DIR_BASE    5'h10
`define GPIO_PULL_BASE   5'h1C
`define GPIO_PULL_REGS   4
`define GPIO_GROUP_W     4
`define GPIO_RST_DIR     8'h00
`define GPIO_RST_LATCH   8'h00
`define GPIO_RST_PULL    8'h00
`define GPIO_IN_ONLY_BIT 69
`endif

// ===== core/gpio_pkg.sv
// types of the programmable port block
// assumes gpio_defs.svh for widths
`include "gpio_defs.svh"
package gpio_pkg;
    typedef struct packed
    {
        logic [`GPIO_AW-1:0] addr;
        logic [`GPIO_DW-1:0] wdata;
        logic                we;
        logic                re;
    } gpio_req_t;

    typedef enum logic [1:0]
    {
        GPIO_SEL_NONE,
        GPIO_SEL_DATA,
        GPIO_SEL_DIR,
        GPIO_SEL_PULL
    } gpio_sel_t;
endpackage : gpio_pkg

// ===== test/gpio_pins_model.sv
// board side of the port pins: wiring, pull-ups and outside drivers
// assumes one pin per bit, pin level settled within each clk cycle
`timescale 1ns/1ps
module gpio_pins_model (
    input  wire logic        clk,
    input  wire logic [87:0] pad_out_q,
    input  wire logic [87:0] pad_oe_q,
    input  wire logic [87:0] pull_en_q,
    input  wire logic [87:0] ext_en,
    input  wire logic [87:0] ext_val,
    output logic [87:0]      pad_in
);
    logic float_q = 1'b0;
    // undriven pins with no pull-up toggle so a stale level never reads as a match
    always @(posedge clk)
        float_q <= ~float_q;
    // pin from driver, pull-up or nothing
    assign pad_in = (pad_oe_q & pad_out_q) | (~pad_oe_q & ext_en & ext_val)
        | (~pad_oe_q & ~ext_en & (pull_en_q | {88{float_q}}));
endmodule : gpio_pins_model

// ===== test/tb_gpio_ports.sv
// directed bench of the programmable port block
// assumes gpio_pins_model on the pins; pins 0..3 have no outside driver
`timescale 1ns/1ps
module tb_gpio_ports;
    logic                clk;
    logic                rstn = 1'b0;
    gpio_pkg::gpio_req_t req = '0;
    logic [7:0]          rdata_q;
    logic [87:0]         pad_in, pad_out_q, pad_oe_q, pull_en_q;
    logic [87:0]         periph_oe = '0, periph_out = '0, periph_dac = '0;
    logic [87:0]         ext_en = ~88'hF, ext_val = {11{8'hE3}};
    int                  fails, n_checks, cycles;
    gpio_ports gpio_ports_i (.clk(clk), .rstn(rstn), .bus_req(req), .rdata_q(rdata_q),
        .pad_in(pad_in), .pad_out_q(pad_out_q), .pad_oe_q(pad_oe_q), .pull_en_q(pull_en_q),
        .periph_oe(periph_oe), .periph_out(periph_out), .periph_dac(periph_dac));
    gpio_pins_model gpio_pins_model_i (.clk(clk), .pad_out_q(pad_out_q), .pad_oe_q(pad_oe_q),
        .pull_en_q(pull_en_q), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(string name, logic [87:0] exp, logic [87:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic wr(logic [4:0] a, logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge clk);
        req.we <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rd(logic [4:0] a, logic [7:0] exp, string name);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge clk);
        req.re <= 1'b0;
        #1;
        chk(name, exp, rdata_q);
    endtask : rd
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fails++;
            complete_run();
        end
    end
    task automatic t_reset();
        #1;
        chk("oe", 88'h0, pad_oe_q);
        chk("pull", 88'h0, pull_en_q);
        rd(5'h10, 8'h00, "dir0");
    endtask : t_reset
    task automatic t_latch();
        wr(5'h00, 8'hA5);
        settle();
        chk("oe0", 88'h0, pad_oe_q[7:0]);
        wr(5'h10, 8'h0F);
        settle();
        chk("oe0", 88'h0F, pad_oe_q[7:0]);
        chk("out0", 88'h5, pad_out_q[3:0]);
        rd(5'h00, 8'hE5, "port0");
    endtask : t_latch
    task automatic t_pull();
        wr(5'h1C, 8'h01);
        wr(5'h10, 8'h0C);
        settle();
        chk("pull0", 88'h03, pull_en_q[7:0]);
        rd(5'h00, 8'hE7, "port0");
    endtask : t_pull
    task automatic t_periph();
        @(posedge clk);
        periph_oe[16] <= 1'b1;
        periph_out[16] <= 1'b1;
        settle();
        chk("oe16", 88'h1, pad_oe_q[16]);
        chk("out16", 88'h1, pad_out_q[16]);
        @(posedge clk);
        periph_dac[16] <= 1'b1;
        settle();
        chk("oe16", 88'h0, pad_oe_q[16]);
        @(posedge clk);
        periph_oe <= '0;
        periph_dac <= '0;
        wr(5'h12, 8'h00);
        rd(5'h02, 8'hE3, "port2");
    endtask : t_periph
    task automatic t_in_only();
        wr(5'h18, 8'hFF);
        settle();
        chk("oe8", 88'hDF, pad_oe_q[71:64]);
        rd(5'h18, 8'hDF, "dir8");
        rd(5'h08, 8'h20, "port8");
        wr(5'h0B, 8'hFF);
        rd(5'h0B, 8'h00, "unmapped");
        rd(5'h1B, 8'h00, "unmapped");
    endtask : t_in_only
    task automatic t_all_out();
        wr(5'h01, 8'h5A);
        for (int k = 0; k < 11; k++)
            wr(5'h10 + k[4:0], 8'hFF);
        settle();
        chk("oe count", 88'd87, 88'($countones(pad_oe_q)));
        chk("out1", 88'h5A, pad_out_q[15:8]);
    endtask : t_all_out
    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_latch();
        t_pull();
        t_periph();
        t_in_only();
        t_all_out();
        complete_run();
    end
endmodule : tb_gpio_ports
